// ===== verilog/dps_bank.sv
// Dual data pointer bank with select register for the core's register space
//
// Behaviour
// [R01] Provide 16-bit pointer for external data accesses
// [R02] First pointer bytes at 0x82 and 0x83
// [R03] Second pointer bytes at 0x84 and 0x85
// [R04] Select bit zero picks first, one picks second
// [R05] Select bit is bit 0 at 0x86
// [R06] Select bits 7..1 ignore writes, read zero
// [R07] Pointer instructions act only on selected pointer
// [R08] Incrementing select register flips the select bit
// [R09] Constant bits ignore writes, return constant
// [R10] Unused bits exist but change no behaviour
// [R11] Software never writes unassigned register addresses
// [R12] Power-on and watchdog reset load reset values
// [R13] Writes to idle pointer leave active untouched
`default_nettype none

module dps_bank
  import dps_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wdt_rst,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output var  logic [7:0]  sfr_rdata,
  output var  logic        sfr_rd_hit,
  input  wire logic        ptr_load,
  input  wire logic [15:0] ptr_load_val,
  input  wire logic        ptr_inc,
  output var  logic [15:0] active_pointer,
  output var  logic        active_sel
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Maps an address to one of the five registers; anything else is none
  function automatic dps_tgt_t dps_decode(input logic [7:0] addr);
    dps_tgt_t t;
    t = DPS_TGT_NONE;
    case (addr)
      DPS_ADDR_A_LOW: begin
        t = DPS_TGT_A_LOW; // [R02]
      end
      DPS_ADDR_A_HIGH: begin
        t = DPS_TGT_A_HIGH; // [R02]
      end
      DPS_ADDR_B_LOW: begin
        t = DPS_TGT_B_LOW; // [R03]
      end
      DPS_ADDR_B_HIGH: begin
        t = DPS_TGT_B_HIGH; // [R03]
      end
      DPS_ADDR_CHOICE: begin
        t = DPS_TGT_CHOICE; // [R05]
      end
      default: begin
        t = DPS_TGT_NONE;
      end
    endcase
    return t;
  endfunction

  // Image of the select register: only the select bit is live.
  function automatic logic [7:0] dps_choice_image(input logic sel);
    logic [7:0] v;
    v = DPS_CHOICE_FIXED; // [R06] [R09]
    v[DPS_SEL_BIT] = sel;
    return v;
  endfunction

  function automatic logic [7:0] dps_low(input logic [15:0] p);
    return p[DPS_BYTE_W-1:0];
  endfunction

  function automatic logic [7:0] dps_high(input logic [15:0] p);
    return p[DPS_PTR_W-1:DPS_BYTE_W];
  endfunction

  // True for the five addresses this bank answers; every other
  // address is left alone so reserved locations stay inert.
  function automatic logic dps_is_mapped(input dps_tgt_t t);
    return (t != DPS_TGT_NONE);
  endfunction

  // Value of the pointer that the select bit names.
  function automatic logic [15:0] dps_pick_value(input dps_pick_t   sel,
                                                 input logic [15:0] a,
                                                 input logic [15:0] b);
    logic [15:0] v;
    v = a;
    if (sel == DPS_PICK_B) begin
      v = b; // [R04]
    end
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Pointer storage
  // ---------------------------------------------------------------
  // Each pointer lives in its own unit; the bank only steers requests.
  // Both units take the watchdog reset too, so a watchdog bite leaves
  // no stale address behind for the next block move.
  dps_ptr_if ptr_a ();
  dps_ptr_if ptr_b ();

  dps_ptr_reg u_ptr_a (
    .clk     (clk),
    .rst     (rst),
    .wdt_rst (wdt_rst),
    .port    (ptr_a.unit)
  );

  dps_ptr_reg u_ptr_b (
    .clk     (clk),
    .rst     (rst),
    .wdt_rst (wdt_rst),
    .port    (ptr_b.unit)
  );

  // ---------------------------------------------------------------
  // Bank state
  // ---------------------------------------------------------------
  // Registered bus answer and registered copy of the active pointer
  typedef struct packed {
    dps_pick_t   sel;
    logic [7:0]  rdata;
    logic        rd_hit;
    logic [15:0] active;
  } dps_bank_state_t;

  dps_bank_state_t st_r;
  dps_bank_state_t st_nxt;

  dps_tgt_t  tgt;
  logic      wr_go;
  logic      rd_go;
  logic      op_on_a;
  logic      op_on_b;

  assign tgt   = dps_decode(sfr_addr);
  assign wr_go = sfr_wr && dps_is_mapped(tgt);
  assign rd_go = sfr_rd && dps_is_mapped(tgt);

  // Instruction ops follow the bit as it stands at the start of the
  // cycle, so a select write in the same cycle only affects later ops.
  assign op_on_a = (st_r.sel == DPS_PICK_A); // [R04] [R07]
  assign op_on_b = (st_r.sel == DPS_PICK_B); // [R04] [R07]

  // ---------------------------------------------------------------
  // Requests to the two pointer units
  // ---------------------------------------------------------------
  // Byte writes go to their own pointer whatever the select bit is,
  // so the idle pointer can be set up while the other one is in use.
  always_comb begin
    ptr_a.wr_low   = 1'b0;
    ptr_a.wr_high  = 1'b0;
    ptr_a.wdata    = sfr_wdata;
    ptr_a.load     = 1'b0;
    ptr_a.load_val = ptr_load_val;
    ptr_a.inc      = 1'b0;
    ptr_b.wr_low   = 1'b0;
    ptr_b.wr_high  = 1'b0;
    ptr_b.wdata    = sfr_wdata;
    ptr_b.load     = 1'b0;
    ptr_b.load_val = ptr_load_val;
    ptr_b.inc      = 1'b0;

    if (wr_go) begin
      case (tgt)
        DPS_TGT_A_LOW: begin
          ptr_a.wr_low = 1'b1; // [R02] [R13]
        end
        DPS_TGT_A_HIGH: begin
          ptr_a.wr_high = 1'b1; // [R02] [R13]
        end
        DPS_TGT_B_LOW: begin
          ptr_b.wr_low = 1'b1; // [R03] [R13]
        end
        DPS_TGT_B_HIGH: begin
          ptr_b.wr_high = 1'b1; // [R03] [R13]
        end
        default: begin
          // Select register write: no pointer byte moves
        end
      endcase
    end

    // Loads and increments reach only the pointer that the bit names,
    // so the idle pointer keeps its value through a block move.
    if (op_on_a) begin
      ptr_a.load = ptr_load; // [R07]
      ptr_a.inc  = ptr_inc;  // [R07]
    end
    if (op_on_b) begin
      ptr_b.load = ptr_load; // [R07]
      ptr_b.inc  = ptr_inc;  // [R07]
    end
  end

  // ---------------------------------------------------------------
  // Select register
  // ---------------------------------------------------------------
  // Only bit 0 is stored. A read-modify-write increment of the
  // register therefore writes 0x01 or 0x02, flipping the bit while
  // the upper bits stay zero.
  dps_pick_t sel_nxt;
  logic      sel_wr;

  assign sel_wr = wr_go && (tgt == DPS_TGT_CHOICE);

  always_comb begin
    sel_nxt = st_r.sel;
    if (sel_wr) begin
      sel_nxt = dps_pick_t'(sfr_wdata[DPS_SEL_BIT]); // [R05] [R06] [R08] [R10]
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Built from registered values, so a read in the same cycle as a
  // write returns the contents from before that write.
  logic [7:0] rd_image;

  always_comb begin
    rd_image = DPS_READ_UNMAPPED;
    case (tgt)
      DPS_TGT_A_LOW: begin
        rd_image = dps_low(ptr_a.value); // [R02]
      end
      DPS_TGT_A_HIGH: begin
        rd_image = dps_high(ptr_a.value); // [R02]
      end
      DPS_TGT_B_LOW: begin
        rd_image = dps_low(ptr_b.value); // [R03]
      end
      DPS_TGT_B_HIGH: begin
        rd_image = dps_high(ptr_b.value); // [R03]
      end
      DPS_TGT_CHOICE: begin
        rd_image = dps_choice_image(st_r.sel); // [R06] [R09]
      end
      default: begin
        rd_image = DPS_READ_UNMAPPED;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rd_hit = 1'b0;
    st_nxt.rdata  = DPS_READ_UNMAPPED;
    st_nxt.sel    = sel_nxt;

    if (rd_go) begin
      st_nxt.rd_hit = 1'b1;
      st_nxt.rdata  = rd_image;
    end

    // Registered copy of the pointer that will be active next cycle,
    // so the core sees the new address right after a load, increment
    // or select change without a combinational path through the bank.
    st_nxt.active = dps_pick_value(st_nxt.sel,      // [R01] [R04]
                                   ptr_a.value_nxt,
                                   ptr_b.value_nxt);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    // Both resets act alike; either one restores every default
    if (rst || wdt_rst) begin
      st_r.sel    <= DPS_PICK_A;       // [R12]
      st_r.rdata  <= DPS_READ_UNMAPPED;
      st_r.rd_hit <= 1'b0;
      st_r.active <= DPS_PTR_RESET;    // [R12]
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Every output is a flop of the bank state, so the core sees no
  // combinational path from its own request back to its inputs.
  assign sfr_rdata      = st_r.rdata;
  assign sfr_rd_hit     = st_r.rd_hit;
  assign active_pointer = st_r.active;
  assign active_sel     = st_r.sel;

endmodule

`default_nettype wire

// ===== verilog/dps_pkg.sv
// Constants and types shared by the dual data pointer bank
`default_nettype none

package dps_pkg;

  // ---------------------------------------------------------------
  // Register addresses in the special-function space
  // ---------------------------------------------------------------
  localparam logic [7:0] DPS_ADDR_A_LOW  = 8'h82;
  localparam logic [7:0] DPS_ADDR_A_HIGH = 8'h83;
  localparam logic [7:0] DPS_ADDR_B_LOW  = 8'h84;
  localparam logic [7:0] DPS_ADDR_B_HIGH = 8'h85;
  localparam logic [7:0] DPS_ADDR_CHOICE = 8'h86;

  // ---------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------
  localparam int         DPS_PTR_W        = 16;
  localparam int         DPS_BYTE_W       = 8;
  localparam int         DPS_SEL_BIT      = 0;
  localparam logic [7:0] DPS_CHOICE_FIXED = 8'h00;
  localparam logic [7:0] DPS_BYTE_RESET   = 8'h00;
  localparam logic [15:0] DPS_PTR_RESET   = 16'h0000;
  localparam logic [15:0] DPS_PTR_STEP    = 16'h0001;
  localparam logic       DPS_SEL_RESET    = 1'b0;
  localparam logic [7:0] DPS_READ_UNMAPPED = 8'h00;

  // Which pointer the choice bit names
  typedef enum logic [0:0] {
    DPS_PICK_A = 1'b0,
    DPS_PICK_B = 1'b1
  } dps_pick_t;

  // Decoded target of a special-function access
  typedef enum logic [2:0] {
    DPS_TGT_NONE   = 3'b000,
    DPS_TGT_A_LOW  = 3'b001,
    DPS_TGT_A_HIGH = 3'b010,
    DPS_TGT_B_LOW  = 3'b011,
    DPS_TGT_B_HIGH = 3'b100,
    DPS_TGT_CHOICE = 3'b101
  } dps_tgt_t;

endpackage

`default_nettype wire

// ===== verilog/dps_ptr_if.sv
// Carrier between the bank control and one pointer storage unit
`default_nettype none

interface dps_ptr_if
  import dps_pkg::*;
();
  logic                 wr_low;
  logic                 wr_high;
  logic [7:0]           wdata;
  logic                 load;
  logic [15:0]          load_val;
  logic                 inc;
  logic [15:0]          value;
  logic [15:0]          value_nxt;

  modport ctrl (
    output wr_low,
    output wr_high,
    output wdata,
    output load,
    output load_val,
    output inc,
    input  value,
    input  value_nxt
  );

  modport unit (
    input  wr_low,
    input  wr_high,
    input  wdata,
    input  load,
    input  load_val,
    input  inc,
    output value,
    output value_nxt
  );
endinterface

`default_nettype wire

// ===== verilog/dps_ptr_reg.sv
// One 16-bit data pointer with byte writes, whole load and increment
`default_nettype none

module dps_ptr_reg
  import dps_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    rst,
  input  wire logic    wdt_rst,
  dps_ptr_if.unit      port
);

  typedef struct packed {
    logic [15:0] ptr;
  } dps_unit_state_t;

  dps_unit_state_t st_r;
  dps_unit_state_t st_nxt;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Instruction load/increment win over a byte write in the same
  // cycle; the core never issues both, this only fixes the outcome.
  always_comb begin
    st_nxt = st_r;
    if (port.load) begin
      st_nxt.ptr = port.load_val;
    end else if (port.inc) begin
      st_nxt.ptr = st_r.ptr + DPS_PTR_STEP;
    end else begin
      if (port.wr_low) begin
        st_nxt.ptr[DPS_BYTE_W-1:0] = port.wdata;
      end
      if (port.wr_high) begin
        st_nxt.ptr[DPS_PTR_W-1:DPS_BYTE_W] = port.wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || wdt_rst) begin
      st_r.ptr <= DPS_PTR_RESET; // [R12]
    end else begin
      st_r <= st_nxt;
    end
  end

  assign port.value     = st_r.ptr;
  assign port.value_nxt = (rst || wdt_rst) ? DPS_PTR_RESET : st_nxt.ptr;

endmodule

`default_nettype wire

// ===== tb/dps_bank_sva.sv
// Port-level assertions for the dual data pointer bank
`default_nettype none

module dps_bank_sva
  import dps_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wdt_rst,
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        sfr_rd_hit,
  input wire logic        ptr_load,
  input wire logic [15:0] ptr_load_val,
  input wire logic        ptr_inc,
  input wire logic [15:0] active_pointer,
  input wire logic        active_sel
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || wdt_rst);

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  wire logic mapped  = sfr_addr inside {[DPS_ADDR_A_LOW:DPS_ADDR_CHOICE]};
  wire logic sel_wr  = sfr_wr && sfr_addr == DPS_ADDR_CHOICE;
  // Byte write aimed at the pointer that is not selected
  wire logic idle_wr = sfr_wr && sfr_addr[7:1] == (active_sel ? 7'h41 : 7'h42);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_read_hit:
    assert property (sfr_rd && mapped |=> sfr_rd_hit)
    else $error("bank read gave no hit");
  a_read_miss:
    assert property (sfr_rd && !mapped |=> !sfr_rd_hit && sfr_rdata == 8'h00)
    else $error("unmapped read answered");
  a_read_quiet:
    assert property (!sfr_rd |=> !sfr_rd_hit && sfr_rdata == 8'h00)
    else $error("read data without a read");
  a_sel_readback:
    assert property (sfr_rd && sfr_addr == DPS_ADDR_CHOICE |=> sfr_rdata[7:1] == 7'h00)
    else $error("select upper bits not zero");
  a_ptr_load:
    assert property (ptr_load && !sel_wr |=> active_pointer == $past(ptr_load_val))
    else $error("load missed active pointer");
  a_ptr_inc:
    assert property (ptr_inc && !ptr_load && !sel_wr |=> active_pointer == $past(active_pointer) + 16'h0001)
    else $error("increment missed active pointer");
  a_sel_write:
    assert property (sel_wr |=> active_sel == $past(sfr_wdata[0]))
    else $error("select bit not written");
  a_sel_hold:
    assert property (!sel_wr |=> $stable(active_sel))
    else $error("select bit moved");
  a_idle_write:
    assert property (idle_wr && !ptr_load && !ptr_inc && !sel_wr |=> $stable(active_pointer))
    else $error("idle pointer write leaked");
  a_reset_vals:
    assert property (disable iff (1'b0) rst || wdt_rst |=> active_pointer == 16'h0000 && !active_sel)
    else $error("reset values wrong");

  c_load_inc: cover property (ptr_load ##1 ptr_inc);
  c_sel_flip: cover property (sel_wr ##1 $changed(active_sel));
  c_miss:     cover property (sfr_rd && !mapped);
endmodule

`default_nettype wire

// ===== tb/dps_core_model.sv
// Core-side model issuing one cycle of register and pointer requests, in any mix, per cyc call
`default_nettype none

module dps_core_model
  import dps_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [7:0]  sfr_rdata,
  input  wire logic        sfr_rd_hit,
  output var  logic [7:0]  sfr_addr,
  output var  logic        sfr_wr,
  output var  logic        sfr_rd,
  output var  logic [7:0]  sfr_wdata,
  output var  logic        ptr_load,
  output var  logic [15:0] ptr_load_val,
  output var  logic        ptr_inc
);
  timeunit 1ns;
  timeprecision 1ps;

  initial {sfr_addr, sfr_wr, sfr_rd, sfr_wdata, ptr_load, ptr_load_val, ptr_inc} = '0;

  // Entered at a falling edge, op is {wr, rd, load, inc}; unused buses show garbage
  task automatic cyc(input logic [3:0] op, input logic [7:0] a, input logic [15:0] v,
                     output logic [7:0] q, output logic h);
    {sfr_wr, sfr_rd, ptr_load, ptr_inc} = op;
    sfr_addr = (op[3] || op[2]) ? a : ~sfr_addr;
    sfr_wdata = op[3] ? v[7:0] : ~sfr_wdata;
    ptr_load_val = op[1] ? v : ~ptr_load_val;
    @(negedge clk);
    q = sfr_rdata;
    h = sfr_rd_hit;
  endtask

  // Switch pointers the way software does: read, add one, write back
  task automatic flip_sel();
    logic [7:0] q;
    logic       h;
    cyc(4'h4, DPS_ADDR_CHOICE, 16'h0000, q, h);
    cyc(4'h8, DPS_ADDR_CHOICE, {8'h00, q + 8'h01}, q, h);
  endtask
endmodule

`default_nettype wire

// ===== tb/dps_bank_tb.sv
// Self-checking bench for the dual data pointer bank
`default_nettype none

module dps_bank_tb
  import dps_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [3:0]  op;
    logic [7:0]  a;
    logic [15:0] v;
    logic [7:0]  er;
    logic [1:0]  ef;
    logic [15:0] ep;
  } dps_row_t;

  // Columns: op {wr,rd,load,inc}, address, value, read data, {hit,sel}, active pointer
  dps_row_t rows [17] = '{
    '{4'h8, 8'h82, 16'h0012, 8'h00, 2'h0, 16'h0012}, '{4'h8, 8'h83, 16'h00ab, 8'h00, 2'h0, 16'hab12},
    '{4'h8, 8'h84, 16'h0034, 8'h00, 2'h0, 16'hab12}, '{4'h8, 8'h85, 16'h00cd, 8'h00, 2'h0, 16'hab12},
    '{4'h4, 8'h84, 16'h0000, 8'h34, 2'h2, 16'hab12}, '{4'h4, 8'h85, 16'h0000, 8'hcd, 2'h2, 16'hab12},
    '{4'h8, 8'h86, 16'h00fe, 8'h00, 2'h0, 16'hab12}, '{4'h8, 8'h86, 16'h00ff, 8'h00, 2'h1, 16'hcd34},
    '{4'h4, 8'h86, 16'h0000, 8'h01, 2'h3, 16'hcd34}, '{4'h2, 8'h00, 16'h1000, 8'h00, 2'h1, 16'h1000},
    '{4'h1, 8'h00, 16'h0000, 8'h00, 2'h1, 16'h1001}, '{4'h8, 8'h82, 16'h0055, 8'h00, 2'h1, 16'h1001},
    '{4'h4, 8'h87, 16'h0000, 8'h00, 2'h1, 16'h1001}, '{4'h8, 8'h86, 16'h0002, 8'h00, 2'h0, 16'hab55},
    '{4'h2, 8'h00, 16'hffff, 8'h00, 2'h0, 16'hffff}, '{4'h1, 8'h00, 16'h0000, 8'h00, 2'h0, 16'h0000},
    '{4'h4, 8'h84, 16'h0000, 8'h01, 2'h2, 16'h0000}};

  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        wdt_rst = 1'h0;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, q;
  logic        sfr_wr, sfr_rd, sfr_rd_hit, ptr_load, ptr_inc, active_sel, h;
  logic [15:0] ptr_load_val, active_pointer;
  int          fails = 0;
  int          checked = 0;

  always #12.5 clk = ~clk;

  dps_bank dut (
    .clk, .rst, .wdt_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_rd_hit,
    .ptr_load, .ptr_load_val, .ptr_inc, .active_pointer, .active_sel
  );
  dps_core_model u_core (
    .clk, .sfr_rdata, .sfr_rd_hit, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .ptr_load, .ptr_load_val, .ptr_inc
  );

  // ---------------------------------------------------------------
  // Compare and closing tasks
  // ---------------------------------------------------------------
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp16({8'h00, got}, {8'h00, exp});
  endtask
  task automatic cmpf(input logic [1:0] got, input logic [1:0] exp);
    cmp16({14'h0000, got}, {14'h0000, exp});
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // A hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'h0;
    cmp16(active_pointer, 16'h0000);
    $display("reset test done");
    foreach (rows[k]) begin
      u_core.cyc(rows[k].op, rows[k].a, rows[k].v, q, h);
      cmp8(q, rows[k].er);
      cmpf({h, active_sel}, rows[k].ef);
      cmp16(active_pointer, rows[k].ep);
    end
    $display("table test done");
    u_core.cyc(4'h3, 8'h00, 16'h2222, q, h);
    cmp16(active_pointer, 16'h2222);
    u_core.cyc(4'hc, 8'h82, 16'h0077, q, h);
    cmp8(q, 8'h22);
    u_core.flip_sel();
    cmp16(active_pointer, 16'h1001);
    u_core.flip_sel();
    cmpf({1'h0, active_sel}, 2'h0);
    cmp16(active_pointer, 16'h2277);
    $display("priority and switch test done");
    u_core.flip_sel();
    cmp16(active_pointer, 16'h1001);
    wdt_rst = 1'h1;
    u_core.cyc(4'h0, 8'h00, 16'h0000, q, h);
    wdt_rst = 1'h0;
    cmp16(active_pointer, 16'h0000);
    cmpf({1'h0, active_sel}, 2'h0);
    u_core.cyc(4'h4, 8'h85, 16'h0000, q, h);
    cmp8(q, 8'h00);
    $display("watchdog test done");
    end_of_test();
  end
endmodule

bind dps_bank dps_bank_sva u_sva (
  .clk, .rst, .wdt_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_rd_hit,
  .ptr_load, .ptr_load_val, .ptr_inc, .active_pointer, .active_sel
);

`default_nettype wire
